// *** logic/chp_pkg.sv ***
package chp_pkg;

	// Access modes
	typedef enum logic [1:0] {
		CHP_MODE_MEM,
		CHP_MODE_IO,
		CHP_MODE_IDE
	} chp_mode_t;

	// Byte lane selection
	typedef enum logic [1:0] {
		CHP_LANE_NONE,
		CHP_LANE_EVEN,
		CHP_LANE_ODD,
		CHP_LANE_WORD
	} chp_lane_t;

	localparam int          CHP_DATA_W      = 16;
	localparam int          CHP_ADDR_W      = 3;
	localparam int          CHP_SECTOR_B    = 512;
	localparam int          CHP_INIT_NS     = 2000;
	localparam int          CHP_CLK_NS      = 8;
	localparam int          CHP_INIT_CYC    = (CHP_INIT_NS + CHP_CLK_NS - 1) / CHP_CLK_NS;
	localparam int          CHP_PULSE_NS    = 80;
	localparam int          CHP_PULSE_CYC   = (CHP_PULSE_NS + CHP_CLK_NS - 1) / CHP_CLK_NS;
	localparam logic [15:0] CHP_WORD_RESET  = 16'h0000;
	localparam int          CHP_ODD_LSB     = 8;

	// Host access as seen by the core side
	typedef struct packed {
		logic [CHP_ADDR_W-1:0] addr;
		logic                  write;
		logic                  ctrl_block;
		logic                  attr;
		chp_lane_t             lane;
		logic [CHP_DATA_W-1:0] wdata;
	} chp_req_t;

endpackage

// *** logic/chp_skid_buf.sv ***
`timescale 1ns/100ps
module chp_skid_buf
	import chp_pkg::*;
#(
	parameter int WIDTH = CHP_DATA_W
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rd_q];

	// Storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end

	a_buf_no_over: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cnt_q == 2'h2) |-> !in_ready) else $error("buffer accepted while full");

endmodule

// *** logic/chp_host_port.sv ***
`timescale 1ns/100ps
module chp_host_port
	import chp_pkg::*;
#(
	parameter int INIT_CYC  = CHP_INIT_CYC,
	parameter int SECTOR_B  = CHP_SECTOR_B
) (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	// Host selects and strobes
	input  wire logic                  card_enable_low_b,
	input  wire logic                  card_enable_high_b,
	input  wire logic [CHP_ADDR_W-1:0] host_address_low,
	input  wire logic                  io_read_strobe_b,
	input  wire logic                  io_write_strobe_b,
	input  wire logic                  mem_read_b,
	input  wire logic                  mem_write_b,
	input  wire logic                  attribute_select_b,
	input  wire logic                  ide_mode_select,
	input  wire logic                  drive_number_select_b,
	input  wire logic                  dma_acknowledge_in_b,
	input  wire logic                  io_mode_strap,
	// Host data bus
	input  wire logic [CHP_DATA_W-1:0] host_data_bus_in,
	output logic      [CHP_DATA_W-1:0] host_data_bus_out,
	output logic                       host_data_bus_oe,
	// Host status outputs
	output logic                       ready_busy_out,
	output logic                       card_irq_out_b,
	output logic                       ide_irq_out,
	output logic                       cycle_extend_b,
	output logic                       battery_status_one,
	output logic                       battery_status_two,
	output logic                       status_change_out_b,
	output logic                       dma_request_out,
	// Master/slave lines
	input  wire logic                  pass_diagnostic_in,
	output logic                       pass_diagnostic_out,
	output logic                       pass_diagnostic_oe,
	input  wire logic                  active_slave_present_in_b,
	output logic                       active_slave_present_out_b,
	output logic                       active_slave_present_oe,
	// Core side
	input  wire logic                  iface_ready,
	input  wire logic                  irq_req,
	input  wire logic                  irq_level_mode,
	input  wire logic                  diag_done,
	input  wire logic                  disk_active,
	input  wire logic                  status_changed,
	input  wire logic                  status_change_en,
	input  wire logic                  dma_pending,
	output logic                       req_valid,
	input  wire logic                  req_ready,
	output chp_req_t                   req_out,
	input  wire logic                  rd_valid,
	output logic                       rd_ready,
	input  wire logic [CHP_DATA_W-1:0] rd_data,
	output logic                       mode_is_ide,
	output logic                       device_one,
	output logic                       sector_done
);

	typedef enum logic [1:0] {
		ST_INIT,
		ST_IDLE,
		ST_BUSY,
		ST_HOLD
	} chp_state_t;

	chp_state_t               st_q;
	chp_mode_t                mode_q;
	logic                     dev1_q;
	logic                     strap_done_q;
	logic [31:0]              init_cnt_q;
	logic [31:0]              pulse_cnt_q;
	logic [15:0]              word_cnt_q;
	logic                     sect_end_q;
	logic [CHP_DATA_W-1:0]    rdat_q;
	logic                     oe_q;
	logic                     irq_q;
	logic                     irq_d1_q;
	chp_req_t                 req_d;
	logic                     rd_strobe;
	logic                     wr_strobe;
	logic                     sel;
	logic                     access;
	logic                     enq_ready;
	logic                     deq_valid;
	logic [$bits(chp_req_t)-1:0] deq_bits;
	chp_lane_t                lane;

	assign mode_is_ide = (mode_q == CHP_MODE_IDE);
	assign device_one  = dev1_q;

	// Mode and device strap capture after reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q       <= CHP_MODE_MEM;
			dev1_q       <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			if (!ide_mode_select) begin
				mode_q <= CHP_MODE_IDE;
				dev1_q <= drive_number_select_b;
			end else begin
				mode_q <= io_mode_strap ? CHP_MODE_IO : CHP_MODE_MEM;
				dev1_q <= 1'b0;
			end
		end
	end

	// Lane decode from enables and address bit zero
	always_comb begin
		lane = CHP_LANE_NONE;
		if (mode_q == CHP_MODE_IDE) begin
			lane = CHP_LANE_WORD;
		end else if (!card_enable_low_b && !card_enable_high_b) begin
			lane = CHP_LANE_WORD;
		end else if (!card_enable_low_b) begin
			lane = host_address_low[0] ? CHP_LANE_ODD : CHP_LANE_EVEN;
		end else if (!card_enable_high_b) begin
			lane = CHP_LANE_ODD;
		end
	end

	// Strobe and select decode per mode
	always_comb begin
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		sel       = 1'b0;
		unique case (mode_q)
			CHP_MODE_MEM: begin
				sel       = (lane != CHP_LANE_NONE);
				rd_strobe = !mem_read_b;
				wr_strobe = !mem_write_b;
			end
			CHP_MODE_IO: begin
				sel       = (lane != CHP_LANE_NONE);
				rd_strobe = iface_ready && (!io_read_strobe_b || (!mem_read_b && !attribute_select_b));
				wr_strobe = iface_ready && (!io_write_strobe_b || (!mem_write_b && !attribute_select_b));
			end
			CHP_MODE_IDE: begin
				sel       = !card_enable_low_b || !card_enable_high_b || !dma_acknowledge_in_b;
				rd_strobe = iface_ready && !io_read_strobe_b;
				wr_strobe = iface_ready && !io_write_strobe_b;
			end
			default: begin
				sel = 1'b0;
			end
		endcase
	end

	assign access = sel && (rd_strobe ^ wr_strobe) && strap_done_q;

	// Request fields
	always_comb begin
		req_d            = '0;
		req_d.addr       = host_address_low;
		req_d.write      = wr_strobe;
		req_d.lane       = lane;
		req_d.ctrl_block = mode_is_ide && card_enable_low_b && !card_enable_high_b;
		req_d.attr       = (mode_q == CHP_MODE_MEM) ? !attribute_select_b : 1'b0;
		req_d.wdata      = host_data_bus_in;
		if (lane == CHP_LANE_ODD && !card_enable_low_b) begin
			req_d.wdata = {host_data_bus_in[CHP_ODD_LSB +: 8], host_data_bus_in[CHP_ODD_LSB +: 8]};
		end
	end

	// Access sequencer
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q       <= ST_INIT;
			init_cnt_q <= 32'h0;
		end else begin
			unique case (st_q)
				ST_INIT: begin
					init_cnt_q <= init_cnt_q + 32'h1;
					if (init_cnt_q >= 32'(INIT_CYC - 1)) begin
						st_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (access && enq_ready) begin
						st_q <= wr_strobe ? ST_HOLD : ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (rd_valid) begin
						st_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (!rd_strobe && !wr_strobe) begin
						st_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign rd_ready = (st_q == ST_BUSY);

	// Read data register and bus drive
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdat_q <= CHP_WORD_RESET;
			oe_q   <= 1'b0;
		end else begin
			if (st_q == ST_BUSY && rd_valid) begin
				rdat_q <= (lane == CHP_LANE_ODD && !card_enable_low_b) ?
					{rd_data[CHP_ODD_LSB +: 8], rd_data[CHP_ODD_LSB +: 8]} : rd_data;
			end
			oe_q <= sel && rd_strobe && (st_q == ST_HOLD);
		end
	end

	assign host_data_bus_out = rdat_q;
	assign host_data_bus_oe  = oe_q;

	// Sector word count
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			word_cnt_q <= 16'h0;
			sect_end_q <= 1'b0;
		end else if (st_q == ST_IDLE && access && enq_ready && host_address_low == '0 && !req_d.ctrl_block) begin
			word_cnt_q <= (word_cnt_q == 16'(SECTOR_B / 2 - 1)) ? 16'h0 : word_cnt_q + 16'h1;
			sect_end_q <= (word_cnt_q == 16'(SECTOR_B / 2 - 1));
		end else if (st_q == ST_IDLE) begin
			sect_end_q <= 1'b0;
		end
	end

	assign sector_done = sect_end_q && (st_q == ST_HOLD);

	// Interrupt shaping
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_d1_q    <= 1'b0;
			irq_q       <= 1'b0;
			pulse_cnt_q <= 32'h0;
		end else begin
			irq_d1_q <= irq_req;
			if (irq_level_mode) begin
				irq_q <= irq_req;
			end else if (irq_req && !irq_d1_q) begin
				irq_q       <= 1'b1;
				pulse_cnt_q <= 32'(CHP_PULSE_CYC);
			end else if (pulse_cnt_q != 32'h0) begin
				pulse_cnt_q <= pulse_cnt_q - 32'h1;
				irq_q       <= (pulse_cnt_q != 32'h1);
			end else begin
				irq_q <= 1'b0;
			end
		end
	end

	assign ready_busy_out      = (mode_q == CHP_MODE_MEM) ? (st_q != ST_INIT) : 1'b1;
	assign card_irq_out_b      = !((mode_q == CHP_MODE_IO) && irq_q);
	assign ide_irq_out         = mode_is_ide && irq_req;
	assign cycle_extend_b      = !(st_q == ST_BUSY || (st_q == ST_IDLE && access && !enq_ready));
	assign battery_status_one  = (mode_q == CHP_MODE_IO) ? !(status_change_en && status_changed) : 1'b1;
	assign battery_status_two  = 1'b1;
	assign status_change_out_b = battery_status_one;
	assign dma_request_out     = mode_is_ide && dma_pending;

	// Master/slave handshake lines, driven only when enabled: slave present drives low, pass diagnostic drives high
	assign pass_diagnostic_out        = 1'b1;
	assign pass_diagnostic_oe         = mode_is_ide && dev1_q && diag_done;
	assign active_slave_present_out_b = 1'b0;
	assign active_slave_present_oe    = mode_is_ide && (dev1_q ? diag_done : disk_active);

	chp_skid_buf #(
		.WIDTH ($bits(chp_req_t))
	) u_req_buf (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.in_valid  (st_q == ST_IDLE && access),
		.in_ready  (enq_ready),
		.in_data   (req_d),
		.out_valid (deq_valid),
		.out_ready (req_ready),
		.out_data  (deq_bits)
	);

	assign req_valid = deq_valid;
	assign req_out   = chp_req_t'(deq_bits);

	a_busy_init: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(st_q == ST_INIT && mode_q == CHP_MODE_MEM) |-> !ready_busy_out) else $error("ready high during init");
	a_mem_io_ign: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode_q == CHP_MODE_MEM && mem_read_b && mem_write_b) |-> !access) else $error("memory mode took io strobe");
	a_not_ready_ign: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode_q != CHP_MODE_MEM && !iface_ready) |-> !access) else $error("strobe taken before setup");
	a_ide_irq_hi: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode_is_ide && irq_req) |-> ide_irq_out && card_irq_out_b) else $error("ide irq not high");
	a_mode_fixed: assert property (@(posedge ref_clk) disable iff (!rst_b)
		strap_done_q |=> $stable(mode_q) && $stable(dev1_q)) else $error("mode changed after strap");
	a_diag_dev0: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!dev1_q |-> !pass_diagnostic_oe) else $error("device 0 drove diagnostic");
	a_extend_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(st_q == ST_BUSY) |-> !cycle_extend_b) else $error("cycle not stretched");
	a_batt_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode_q == CHP_MODE_MEM) |-> battery_status_one && battery_status_two) else $error("battery low");
	a_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!irq_level_mode && irq_req && !irq_d1_q) |=> irq_q [*3]) else $error("pulse too short");
	a_lane_word: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode_q != CHP_MODE_IDE && !card_enable_low_b && !card_enable_high_b) |-> lane == CHP_LANE_WORD)
		else $error("word lane not chosen");

endmodule

// *** verification/chp_host_model.sv ***
`timescale 1ns/100ps
// Host side: drives selects and strobes, holds them while the cycle is stretched
module chp_host_model
	import chp_pkg::*;
(
	// Clock and device status
	input  wire logic                  ref_clk,
	input  wire logic                  ready_busy_out,
	input  wire logic                  cycle_extend_b,
	input  wire logic                  host_data_bus_oe,
	input  wire logic [CHP_DATA_W-1:0] host_data_bus_out,
	// Host drive
	output logic                       card_enable_low_b,
	output logic                       card_enable_high_b,
	output logic      [CHP_ADDR_W-1:0] host_address_low,
	output logic                       io_read_strobe_b,
	output logic                       io_write_strobe_b,
	output logic                       mem_read_b,
	output logic                       mem_write_b,
	output logic      [CHP_DATA_W-1:0] host_drive
);
	initial begin
		{card_enable_high_b, card_enable_low_b} = 2'h3;
		{io_read_strobe_b, io_write_strobe_b, mem_read_b, mem_write_b} = 4'hf;
		host_address_low = 3'h0;
		host_drive = 16'h5a5a;
	end

	task automatic access(input logic wr, input logic io, input logic [1:0] ce_b, input logic [2:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic ok);
		int n;
		int hi;
		n = 0;
		hi = 0;
		ok = 1'b0;
		q = 16'h0000;
		while (ready_busy_out !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		{card_enable_high_b, card_enable_low_b} <= ce_b;
		host_address_low <= a;
		host_drive <= d;
		io_write_strobe_b <= !(io && wr);
		io_read_strobe_b <= !(io && !wr);
		mem_write_b <= !(!io && wr);
		mem_read_b <= !(!io && !wr);
		n = 0;
		while (n < 40 && !ok) begin
			@(posedge ref_clk);
			n++;
			hi = (cycle_extend_b === 1'b1) ? hi + 1 : 0;
			if (wr)
				ok = (hi >= 3);
			else if (host_data_bus_oe === 1'b1 && hi > 0) begin
				ok = 1'b1;
				q = host_data_bus_out;
			end
		end
		{io_read_strobe_b, io_write_strobe_b, mem_read_b, mem_write_b} <= 4'hf;
		{card_enable_high_b, card_enable_low_b} <= 2'h3;
		host_drive <= ~d;
		repeat (2) @(posedge ref_clk);
	endtask
endmodule

// *** verification/test_chp_host_port.sv ***
`timescale 1ns/100ps
module test_chp_host_port
	import chp_pkg::*;
;
	localparam int INIT = 4;
	localparam int SECT = 8;
	logic                  ref_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  ide_mode_select, drive_number_select_b, attribute_select_b, io_mode_strap;
	logic                  dma_acknowledge_in_b, iface_ready, irq_req, irq_level_mode, diag_done;
	logic                  disk_active, status_changed, status_change_en, dma_pending, req_ready, rd_valid;
	logic [CHP_DATA_W-1:0] rd_data, host_data_bus_in, host_data_bus_out, host_drive;
	logic                  card_enable_low_b, card_enable_high_b, io_read_strobe_b, io_write_strobe_b;
	logic                  mem_read_b, mem_write_b, host_data_bus_oe, ready_busy_out, card_irq_out_b;
	logic                  ide_irq_out, cycle_extend_b, battery_status_one, battery_status_two;
	logic                  status_change_out_b, dma_request_out, pass_diagnostic_in, pass_diagnostic_out;
	logic                  pass_diagnostic_oe, active_slave_present_in_b, active_slave_present_out_b;
	logic                  active_slave_present_oe, req_valid, rd_ready, mode_is_ide, device_one, sector_done;
	logic [CHP_ADDR_W-1:0] host_address_low;
	chp_req_t              req_out, er, mr;
	chp_req_t              exp_q[$], msk_q[$];
	chp_mode_t             md;
	logic [31:0]           seed = 32'h00011e09, rr = 32'h00011e09;
	bit                    stall, sd_seen;
	int                    bad_count, compares;

	assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : host_drive;
	assign pass_diagnostic_in = pass_diagnostic_oe ? pass_diagnostic_out : 1'b0;
	assign active_slave_present_in_b = active_slave_present_oe ? active_slave_present_out_b : 1'b1;

	always #(CHP_CLK_NS / 2) ref_clk = ~ref_clk;

	chp_host_port #(.INIT_CYC(INIT), .SECTOR_B(SECT)) chp_host_port_i (
		.ref_clk, .rst_b, .card_enable_low_b, .card_enable_high_b, .host_address_low, .io_read_strobe_b,
		.io_write_strobe_b, .mem_read_b, .mem_write_b, .attribute_select_b, .ide_mode_select,
		.drive_number_select_b, .dma_acknowledge_in_b, .io_mode_strap, .host_data_bus_in, .host_data_bus_out,
		.host_data_bus_oe, .ready_busy_out, .card_irq_out_b, .ide_irq_out, .cycle_extend_b, .battery_status_one,
		.battery_status_two, .status_change_out_b, .dma_request_out, .pass_diagnostic_in, .pass_diagnostic_out,
		.pass_diagnostic_oe, .active_slave_present_in_b, .active_slave_present_out_b, .active_slave_present_oe,
		.iface_ready, .irq_req, .irq_level_mode, .diag_done, .disk_active, .status_changed, .status_change_en,
		.dma_pending, .req_valid, .req_ready, .req_out, .rd_valid, .rd_ready, .rd_data, .mode_is_ide,
		.device_one, .sector_done
	);

	chp_host_model chp_host_model_i (
		.ref_clk, .ready_busy_out, .cycle_extend_b, .host_data_bus_oe, .host_data_bus_out, .card_enable_low_b,
		.card_enable_high_b, .host_address_low, .io_read_strobe_b, .io_write_strobe_b, .mem_read_b,
		.mem_write_b, .host_drive
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic rnd(output logic [15:0] v);
		seed = xs(seed);
		v = seed[15:0];
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Core side: random request stall, read word answered one cycle after rd_ready
	always @(posedge ref_clk) begin
		rr <= xs(rr);
		req_ready <= !stall && rr[3];
		rd_valid <= rd_ready && !rd_valid;
		if (sector_done === 1'b1)
			sd_seen <= 1'b1;
		if (rst_b && req_valid === 1'b1 && req_ready === 1'b1 && req_out.write === 1'b1) begin
			if (exp_q.size() == 0)
				check("req_unexpected", 32'h1, 32'h0);
			else begin
				er = exp_q.pop_front();
				mr = msk_q.pop_front();
				check("req_fields", 32'(req_out & mr), 32'(er & mr));
			end
		end
	end

	task automatic do_reset(input chp_mode_t m, input logic dev);
		int n;
		rst_b <= 1'b0;
		md = m;
		ide_mode_select <= (m != CHP_MODE_IDE);
		io_mode_strap <= (m == CHP_MODE_IO);
		drive_number_select_b <= dev;
		tick(16);
		check("busy_in_reset", 32'(ready_busy_out), 32'h0);
		rst_b <= 1'b1;
		n = 0;
		while (ready_busy_out !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		if (m == CHP_MODE_MEM)
			check("init_cycles", 32'(n >= INIT && n <= INIT + 3), 32'h1);
		tick(2);
		check("mode_ide", 32'(mode_is_ide), 32'(m == CHP_MODE_IDE));
		check("device_one", 32'(device_one), 32'(m == CHP_MODE_IDE && dev));
	endtask

	task automatic do_wr(input logic io, input logic [1:0] ce, input logic [2:0] a, input logic at,
		input chp_lane_t ln, input logic tk);
		logic [15:0] d;
		logic [15:0] q;
		logic ok;
		chp_req_t r;
		chp_req_t m;
		rnd(d);
		attribute_select_b <= !at;
		r = '{addr: a, write: 1'b1, ctrl_block: (md == CHP_MODE_IDE && ce == 2'b01), attr: at, lane: ln,
			wdata: (ln == CHP_LANE_ODD && ce == 2'b10) ? {2{d[15:8]}} : d};
		m = '{addr: 3'h7, write: 1'b1, ctrl_block: 1'b1, attr: md == CHP_MODE_MEM,
			lane: chp_lane_t'({2{md != CHP_MODE_IDE}}), wdata: 16'hffff};
		if (tk) begin
			exp_q.push_back(r);
			msk_q.push_back(m);
		end
		chp_host_model_i.access(1'b1, io, ce, a, d, q, ok);
		check("write_done", 32'(ok), 32'h1);
	endtask

	task automatic do_rd(input logic io, input logic [1:0] ce, input logic [2:0] a, input logic tk);
		logic [15:0] d;
		logic [15:0] q;
		logic ok;
		rnd(d);
		rd_data <= d;
		chp_host_model_i.access(1'b0, io, ce, a, ~d, q, ok);
		check("read_done", 32'(ok), 32'(tk));
		if (tk)
			check("read_data", 32'(q), 32'((md != CHP_MODE_IDE && ce == 2'b10 && a[0]) ? {2{d[15:8]}} : d));
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (exp_q.size() > 0 && n < 200) begin
			tick(1);
			n++;
		end
		check("queue_drained", 32'(exp_q.size()), 32'h0);
	endtask

	task automatic cnt_low(output int c);
		c = 0;
		repeat (30) begin
			tick(1);
			if (card_irq_out_b === 1'b0)
				c++;
		end
	endtask

	task automatic run_all();
		int c;
		int n;
		do_reset(CHP_MODE_MEM, 1'b1);
		check("battery_one", 32'(battery_status_one), 32'h1);
		check("battery_two", 32'(battery_status_two), 32'h1);
		do_wr(1'b1, 2'b00, 3'h0, 1'b0, CHP_LANE_WORD, 1'b0);
		do_rd(1'b1, 2'b00, 3'h0, 1'b0);
		do_wr(1'b0, 2'b10, 3'h2, 1'b0, CHP_LANE_EVEN, 1'b1);
		do_wr(1'b0, 2'b10, 3'h3, 1'b0, CHP_LANE_ODD, 1'b1);
		do_wr(1'b0, 2'b00, 3'h4, 1'b1, CHP_LANE_WORD, 1'b1);
		do_rd(1'b0, 2'b00, 3'h0, 1'b1);
		do_rd(1'b0, 2'b10, 3'h3, 1'b1);
		stall = 1'b1;
		fork
			repeat (3) do_wr(1'b0, 2'b00, 3'h0, 1'b0, CHP_LANE_WORD, 1'b1);
			begin
				n = 0;
				while (cycle_extend_b !== 1'b0 && n < 40) begin
					tick(1);
					n++;
				end
				check("extend_seen", 32'(n < 40), 32'h1);
				tick(4);
				check("extend_held", 32'(cycle_extend_b), 32'h0);
				stall = 1'b0;
			end
		join
		drain();
		do_reset(CHP_MODE_IO, 1'b1);
		check("speaker_high", 32'(battery_status_two), 32'h1);
		iface_ready <= 1'b0;
		do_wr(1'b1, 2'b00, 3'h1, 1'b0, CHP_LANE_WORD, 1'b0);
		do_rd(1'b1, 2'b00, 3'h1, 1'b0);
		iface_ready <= 1'b1;
		do_wr(1'b1, 2'b00, 3'h1, 1'b0, CHP_LANE_WORD, 1'b1);
		do_rd(1'b1, 2'b00, 3'h0, 1'b1);
		{status_changed, status_change_en} <= 2'h3;
		tick(3);
		check("status_change_on", 32'(status_change_out_b), 32'h0);
		status_change_en <= 1'b0;
		tick(3);
		check("status_change_off", 32'(status_change_out_b), 32'h1);
		{irq_req, irq_level_mode} <= 2'h3;
		cnt_low(c);
		check("irq_level", 32'(c >= 28), 32'h1);
		{irq_req, irq_level_mode} <= 2'h0;
		tick(4);
		irq_req <= 1'b1;
		cnt_low(c);
		check("irq_pulse", 32'(c), 32'ha);
		irq_req <= 1'b0;
		drain();
		do_reset(CHP_MODE_IDE, 1'b0);
		drive_number_select_b <= 1'b1;
		tick(2);
		check("device_held", 32'(device_one), 32'h0);
		do_wr(1'b1, 2'b10, 3'h7, 1'b0, CHP_LANE_WORD, 1'b1);
		do_wr(1'b1, 2'b01, 3'h6, 1'b0, CHP_LANE_WORD, 1'b1);
		do_rd(1'b1, 2'b10, 3'h0, 1'b1);
		dma_acknowledge_in_b <= 1'b0;
		do_wr(1'b1, 2'b11, 3'h0, 1'b0, CHP_LANE_WORD, 1'b1);
		dma_acknowledge_in_b <= 1'b1;
		{irq_req, dma_pending, diag_done, disk_active} <= 4'hf;
		tick(3);
		check("ide_irq_on", 32'(ide_irq_out), 32'h1);
		check("dma_req_on", 32'(dma_request_out), 32'h1);
		check("diag_dev0", 32'(pass_diagnostic_oe), 32'h0);
		check("slave_present", 32'(active_slave_present_oe), 32'h1);
		check("diag_line_dev0", 32'(pass_diagnostic_in), 32'h0);
		check("slave_line", 32'(active_slave_present_in_b), 32'h0);
		{irq_req, dma_pending, diag_done, disk_active} <= 4'h0;
		tick(3);
		check("ide_irq_off", 32'(ide_irq_out), 32'h0);
		check("dma_req_off", 32'(dma_request_out), 32'h0);
		drain();
		do_reset(CHP_MODE_IDE, 1'b1);
		diag_done <= 1'b1;
		tick(3);
		check("diag_dev1", 32'(pass_diagnostic_oe), 32'h1);
		check("diag_line_dev1", 32'(pass_diagnostic_in), 32'h1);
		check("slave_dev1", 32'(active_slave_present_in_b), 32'h0);
		for (n = 0; n < SECT / 2; n++) begin
			sd_seen = 1'b0;
			do_wr(1'b1, 2'b10, 3'h0, 1'b0, CHP_LANE_WORD, 1'b1);
			check("sector_done", 32'(sd_seen), 32'(n == SECT / 2 - 1));
		end
		drain();
	endtask

	initial begin
		{ide_mode_select, drive_number_select_b, attribute_select_b, dma_acknowledge_in_b} = 4'hf;
		{io_mode_strap, irq_req, irq_level_mode, diag_done, disk_active} = 5'h00;
		{status_changed, status_change_en, dma_pending, rd_valid} = 4'h0;
		{iface_ready, req_ready} = 2'h3;
		rd_data = 16'h0000;
		stall = 1'b0;
		fork
			run_all();
			begin
				tick(60000);
				check("timeout", 32'h1, 32'h0);
			end
		join_any
		finish_test();
	end
endmodule
